/* File: rtl/port_sc_pkg.sv */
// constants and types for the port status and control upper fields
package port_sc_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] CFG_FLAG_OFS    = 8'h50;
    localparam logic [7:0] PORT1_SC_OFS    = 8'h54;
    localparam logic [7:0] PORT_CAP_OFS    = 8'h60;

    // port1_status_control field positions
    localparam int WAKE_OC_BIT      = 22;
    localparam int WAKE_DETACH_BIT  = 21;
    localparam int WAKE_ATTACH_BIT  = 20;
    localparam int TEST_SEL_HI      = 19;
    localparam int TEST_SEL_LO      = 16;
    localparam int INDICATOR_HI     = 15;
    localparam int INDICATOR_LO     = 14;
    localparam int OWNER_BIT        = 13;
    localparam int POWER_BIT        = 12;
    localparam int LINE_DP_BIT      = 11;
    localparam int LINE_DM_BIT      = 10;
    localparam int ENABLED_BIT      = 2;
    localparam int CONNECT_BIT      = 0;

    // configure flag and capability register fields
    localparam int CFG_FLAG_BIT     = 0;
    localparam int CAP_SWITCH_BIT   = 0;

    // reset values
    localparam logic       CFG_FLAG_RST   = 1'b0;
    localparam logic       POWER_RST      = 1'b0;
    localparam logic       CAP_SWITCH_RST = 1'b1;
    localparam logic       OWNER_RST      = 1'b1;
    localparam logic [3:0] TEST_SEL_RST   = 4'h0;
    localparam logic [2:0] WAKE_EN_RST    = 3'h0;

    // test selector encodings
    typedef enum logic [3:0] {
        TEST_OFF          = 4'h0,
        TEST_J            = 4'h1,
        TEST_K            = 4'h2,
        TEST_SE0_NAK      = 4'h3,
        TEST_PACKET       = 4'h4,
        TEST_FORCE_ENABLE = 4'h5
    } test_sel_type;

    localparam logic [3:0] TEST_LAST_LEGAL = 4'h5;

    // number of pin inputs that pass the synchroniser
    localparam int PIN_COUNT = 3;
    localparam int PIN_DP    = 2;
    localparam int PIN_DM    = 1;
    localparam int PIN_OC    = 0;

endpackage : port_sc_pkg

/* File: rtl/pin_sync_if.sv */
// carrier for synchronised pin levels between the port logic and its synchroniser
`timescale 1ns/1ps
interface pin_sync_if #(
    parameter int WIDTH = 3
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface : pin_sync_if

/* File: rtl/pin_sync.sv */
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // pin levels in, synchronised levels out
    pin_sync_if.sync_side pins
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync width must be at least one");
        end
    end

    // first stage is read only by the second stage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff   <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff   <= pins.raw;
            stable_ff <= meta_ff;
        end
    end

    assign pins.synced = stable_ff;

endmodule : pin_sync

/* File: rtl/usb_port_status_control_upper.sv */
// upper fields of the root-hub port status and control register
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module usb_port_status_control_upper
    import port_sc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // usb data lines and overcurrent sense pin
    input  wire logic        dp_i,
    input  wire logic        dm_i,
    input  wire logic        overcurrent_i,
    // state from the lower port fields
    input  wire logic        port_enabled_i,
    input  wire logic        connect_present_i,
    // port control outputs
    output logic             port_power_on_o,
    output logic             companion_owns_o,
    output logic [3:0]       port_test_select_o,
    output logic             test_drive_j_o,
    output logic             test_drive_k_o,
    output logic             test_se0_nak_o,
    output logic             test_packet_o,
    output logic             test_force_enable_o,
    output logic             attach_report_o,
    output logic             wake_event_o
);

    // synchronised pins
    // an overcurrent pin high at reset shows as an edge two cycles after release
    pin_sync_if #(.WIDTH(PIN_COUNT)) pin_bus ();

    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pins      (pin_bus.sync_side)
    );

    assign pin_bus.raw = {dp_i, dm_i, overcurrent_i};

    // refuse package layouts that the slices below cannot serve
    if (PIN_COUNT != 3) begin : g_bad_pin_count
        $error("pin synchroniser must carry d+, d- and overcurrent");
    end
    if (TEST_SEL_HI - TEST_SEL_LO != 3) begin : g_bad_test_field
        $error("test selector field must be four bits wide");
    end
    if (LINE_DP_BIT != LINE_DM_BIT + 1) begin : g_bad_line_field
        $error("line state bits must be adjacent, d+ above d-");
    end

    // register state
    logic       configure_flag_ff;
    logic       power_switch_capable_ff;
    logic       port_power_ff;
    logic       power_on_ff;
    logic       port_handoff_owner_ff;
    logic [3:0] port_test_select_ff;
    logic       wake_on_overcurrent_en_ff;
    logic       wake_on_detach_en_ff;
    logic       wake_on_attach_en_ff;
    logic       ack_ff;
    logic [31:0] rdata_ff;
    logic       connect_prev_ff;
    logic       oc_prev_ff;
    logic       wake_ff;
    logic       attach_ff;
    logic [5:0] test_dec_ff;

    // bus decode
    // byte lanes gate each field group; other lanes are ignored
    wire        bus_req      = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire        bus_wr       = bus_req & wb_we_i;
    wire        hit_cfg      = (wb_adr_i == CFG_FLAG_OFS);
    wire        hit_port     = (wb_adr_i == PORT1_SC_OFS);
    wire        hit_cap      = (wb_adr_i == PORT_CAP_OFS);
    wire        wr_cfg_lo    = bus_wr & hit_cfg & wb_sel_i[0];
    wire        wr_cap_lo    = bus_wr & hit_cap & wb_sel_i[0];
    wire        wr_port_b1   = bus_wr & hit_port & wb_sel_i[1];
    wire        wr_port_b2   = bus_wr & hit_port & wb_sel_i[2];

    // synchronised pin levels
    wire        line_dp      = pin_bus.synced[PIN_DP];
    wire        line_dm      = pin_bus.synced[PIN_DM];
    wire        oc_level     = pin_bus.synced[PIN_OC];

    // effective power: hard-wired on without switches
    // the switch register keeps its value while the capability is off
    wire        power_eff    = power_switch_capable_ff ? port_power_ff : 1'b1;

    // event detection on real changes while powered
    // powering up with a device already present raises no attach wake,
    // since only a change of the connect level counts as an event
    wire        connect_pwr  = connect_present_i & power_eff;
    wire        attach_evt   = power_eff & connect_present_i & ~connect_prev_ff;
    wire        detach_evt   = power_eff & ~connect_present_i & connect_prev_ff;
    wire        oc_evt       = power_eff & oc_level & ~oc_prev_ff;
    wire        nxt_wake     = (attach_evt & wake_on_attach_en_ff)
                             | (detach_evt & wake_on_detach_en_ff)
                             | (oc_evt & wake_on_overcurrent_en_ff);

    // configure flag rising edge and the write value it sees
    // using the write value lets the owner clear land on the same edge
    wire        nxt_cfg      = wr_cfg_lo ? wb_dat_i[CFG_FLAG_BIT] : configure_flag_ff;
    wire        cfg_rise     = nxt_cfg & ~configure_flag_ff;

    // owner next value: forced by configure flag before software
    // the flag wins over a same-cycle software write so routing never races
    wire        owner_wr_val = wr_port_b1 ? wb_dat_i[OWNER_BIT] : port_handoff_owner_ff;
    wire        nxt_owner    = ~nxt_cfg  ? 1'b1 :
                               cfg_rise ? 1'b0 :
                               owner_wr_val;

    // power next value: overcurrent removal wins over software
    // a cut must win, or a write of one could re-power a shorted port
    wire        oc_cut       = power_switch_capable_ff & port_power_ff & oc_level;
    wire        power_wr_val = wr_port_b1 ? wb_dat_i[POWER_BIT] : port_power_ff;
    wire        nxt_power    = oc_cut ? 1'b0 : power_wr_val;

    // capability next value and the power drive it leaves
    wire        nxt_cap      = wr_cap_lo ? wb_dat_i[CAP_SWITCH_BIT] : power_switch_capable_ff;
    wire        nxt_power_on = nxt_power | ~nxt_cap;

    // test selector write: reserved codes leave the field unchanged
    // otherwise the port would claim a test mode that drives nothing
    wire [3:0]  test_wr      = wb_dat_i[TEST_SEL_HI:TEST_SEL_LO];
    wire        test_legal   = (test_wr <= TEST_LAST_LEGAL);
    wire [3:0]  nxt_test     = (wr_port_b2 & test_legal) ? test_wr : port_test_select_ff;

    // line state only meaningful while disabled, connected and powered
    // reading zero otherwise keeps stale pin levels out of the image
    wire        line_valid   = ~port_enabled_i & connect_present_i & power_eff;
    wire [1:0]  line_state   = line_valid ? {line_dp, line_dm} : 2'b00;

    // read image of port1_status_control; indicator field and reserved read zero
    // no indicator hardware sits behind the indicator field
    logic [31:0] port_image;
    always_comb begin
        port_image                            = 32'h0000_0000;
        port_image[WAKE_OC_BIT]               = wake_on_overcurrent_en_ff & power_eff;
        port_image[WAKE_DETACH_BIT]           = wake_on_detach_en_ff & power_eff;
        port_image[WAKE_ATTACH_BIT]           = wake_on_attach_en_ff & power_eff;
        port_image[TEST_SEL_HI:TEST_SEL_LO]   = port_test_select_ff;
        port_image[OWNER_BIT]                 = port_handoff_owner_ff;
        port_image[POWER_BIT]                 = power_eff;
        port_image[LINE_DP_BIT:LINE_DM_BIT]   = line_state;
        port_image[ENABLED_BIT]               = port_enabled_i & power_eff;
        port_image[CONNECT_BIT]               = connect_pwr;
    end

    // read mux, unmapped addresses read zero
    // every offset answers, so software never stalls the bus
    wire [31:0] cfg_image    = {31'h0000_0000, configure_flag_ff};
    wire [31:0] cap_image    = {31'h0000_0000, power_switch_capable_ff};
    wire [31:0] nxt_rdata    = hit_port ? port_image :
                               hit_cfg  ? cfg_image  :
                               hit_cap  ? cap_image  : 32'h0000_0000;

    // test mode decode
    // one-hot, so at most one line pattern is ever requested
    logic [5:0] nxt_test_dec;
    always_comb begin
        nxt_test_dec = 6'h00;
        unique case (test_sel_type'(port_test_select_ff))
            TEST_OFF:          nxt_test_dec = 6'h00;
            TEST_J:            nxt_test_dec = 6'h01;
            TEST_K:            nxt_test_dec = 6'h02;
            TEST_SE0_NAK:      nxt_test_dec = 6'h04;
            TEST_PACKET:       nxt_test_dec = 6'h08;
            TEST_FORCE_ENABLE: nxt_test_dec = 6'h10;
            default:           nxt_test_dec = 6'h00;
        endcase
    end

    // bus handshake: one wait state, ack dropped the cycle after
    // ack masks the request, so a held strobe is not taken twice
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= bus_req;
            if (bus_req) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // configuration and power state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            configure_flag_ff       <= CFG_FLAG_RST;
            power_switch_capable_ff <= CAP_SWITCH_RST;
            port_power_ff           <= POWER_RST;
            port_handoff_owner_ff   <= OWNER_RST;
            power_on_ff             <= POWER_RST | ~CAP_SWITCH_RST;
        end else begin
            configure_flag_ff     <= nxt_cfg;
            port_power_ff         <= nxt_power;
            port_handoff_owner_ff <= nxt_owner;
            power_switch_capable_ff <= nxt_cap;
            power_on_ff           <= nxt_power_on;
        end
    end

    // wake enables and test selector
    // stored enables survive a power cut; only the read image masks them
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_on_overcurrent_en_ff <= WAKE_EN_RST[2];
            wake_on_detach_en_ff      <= WAKE_EN_RST[1];
            wake_on_attach_en_ff      <= WAKE_EN_RST[0];
            port_test_select_ff       <= TEST_SEL_RST;
        end else begin
            port_test_select_ff <= nxt_test;
            if (wr_port_b2) begin
                wake_on_overcurrent_en_ff <= wb_dat_i[WAKE_OC_BIT];
                wake_on_detach_en_ff      <= wb_dat_i[WAKE_DETACH_BIT];
                wake_on_attach_en_ff      <= wb_dat_i[WAKE_ATTACH_BIT];
            end
        end
    end

    // event history: levels one cycle back for edge detection
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            connect_prev_ff <= 1'b0;
            oc_prev_ff      <= 1'b0;
        end else begin
            connect_prev_ff <= connect_present_i;
            oc_prev_ff      <= oc_level;
        end
    end

    // reported events: wake pulse and power-gated attach level
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_ff   <= 1'b0;
            attach_ff <= 1'b0;
        end else begin
            wake_ff   <= nxt_wake;
            attach_ff <= connect_pwr;
        end
    end

    // test mode lines, one cycle after the selector
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_dec_ff <= 6'h00;
        end else begin
            test_dec_ff <= nxt_test_dec;
        end
    end

    // outputs straight from flip-flops
    // no decode glitch can reach a pin through these
    assign wb_dat_o            = rdata_ff;
    assign wb_ack_o            = ack_ff;
    assign port_power_on_o     = power_on_ff;
    assign companion_owns_o    = port_handoff_owner_ff;
    assign port_test_select_o  = port_test_select_ff;
    assign test_drive_j_o      = test_dec_ff[0];
    assign test_drive_k_o      = test_dec_ff[1];
    assign test_se0_nak_o      = test_dec_ff[2];
    assign test_packet_o       = test_dec_ff[3];
    assign test_force_enable_o = test_dec_ff[4];
    assign attach_report_o     = attach_ff;
    assign wake_event_o        = wake_ff;

endmodule : usb_port_status_control_upper

/* File: tb/usb_device_model.sv */
// attached usb device model: line levels, presence, port enable and overcurrent sense
`timescale 1ns/1ps
module usb_device_model (
    // clock
    input  wire logic ref_clk_i,
    // device side levels
    output logic      dp_o,
    output logic      dm_o,
    output logic      connect_o,
    output logic      enabled_o,
    output logic      overcurrent_o
);
    // nothing attached: host pull-downs hold both lines at se0
    initial begin
        dp_o          = 1'b0;
        dm_o          = 1'b0;
        connect_o     = 1'b0;
        enabled_o     = 1'b0;
        overcurrent_o = 1'b0;
    end

    // low speed idles in k (dm high), full speed in j (dp high)
    task automatic attach(input logic low_speed);
        @(posedge ref_clk_i);
        dp_o      <= ~low_speed;
        dm_o      <= low_speed;
        connect_o <= 1'b1;
    endtask : attach

    // released lines fall back to se0 through the pull-downs
    task automatic detach();
        @(posedge ref_clk_i);
        dp_o      <= 1'b0;
        dm_o      <= 1'b0;
        connect_o <= 1'b0;
    endtask : detach

    // enable comes only from the reset sequence of the lower fields
    task automatic set_enabled(input logic v);
        @(posedge ref_clk_i);
        enabled_o <= v;
    endtask : set_enabled

    // overcurrent sense level
    task automatic set_oc(input logic v);
        @(posedge ref_clk_i);
        overcurrent_o <= v;
    endtask : set_oc
endmodule : usb_device_model

/* File: tb/usb_port_sc_checker.sv */
// concurrent checks on the port status and control upper fields
`timescale 1ns/1ps
module usb_port_sc_checker
    import port_sc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // bus and lower-field inputs
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        port_enabled_i,
    input  wire logic        connect_present_i,
    // port control outputs
    input  wire logic        port_power_on_o,
    input  wire logic        companion_owns_o,
    input  wire logic [3:0]  port_test_select_o,
    input  wire logic        test_drive_j_o,
    input  wire logic        test_drive_k_o,
    input  wire logic        test_se0_nak_o,
    input  wire logic        test_packet_o,
    input  wire logic        test_force_enable_o,
    input  wire logic        attach_report_o,
    input  wire logic        wake_event_o
);
    import port_sc_pkg::*;
    // read answer from the port register; request is still held in the ack cycle
    wire rd54 = wb_ack_o && !wb_we_i && (wb_adr_i == PORT1_SC_OFS);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    reserved_zero_a: assert property (
        wb_ack_o |-> (wb_dat_o[31:23] == 9'h000) && !wb_dat_o[9]) else $error("reserved bits set");
    indicator_zero_a: assert property (
        wb_ack_o |-> wb_dat_o[15:14] == 2'h0) else $error("indicator field not zero");
    wake_masked_a: assert property (
        rd54 && !wb_dat_o[POWER_BIT] |-> wb_dat_o[22:20] == 3'h0) else $error("wake enables shown");
    owner_read_a: assert property (
        rd54 |-> wb_dat_o[OWNER_BIT] == $past(companion_owns_o)) else $error("owner read wrong");
    power_read_a: assert property (
        rd54 |-> wb_dat_o[POWER_BIT] == $past(port_power_on_o)) else $error("power read wrong");
    line_invalid_a: assert property (
        rd54 && !(wb_dat_o[0] && !wb_dat_o[2]) |-> wb_dat_o[11:10] == 2'h0)
        else $error("line state shown when invalid");
    status_low_a: assert property (
        rd54 |-> wb_dat_o[2:0] == {$past(port_enabled_i) && $past(port_power_on_o), 1'b0,
        $past(connect_present_i) && $past(port_power_on_o)}) else $error("status bits wrong");
    test_decode_a: assert property (
        {test_drive_j_o, test_drive_k_o, test_se0_nak_o, test_packet_o, test_force_enable_o} ==
        {$past(port_test_select_o) == TEST_J, $past(port_test_select_o) == TEST_K,
         $past(port_test_select_o) == TEST_SE0_NAK, $past(port_test_select_o) == TEST_PACKET,
         $past(port_test_select_o) == TEST_FORCE_ENABLE}) else $error("test decode wrong");
    attach_gate_a: assert property (
        !$past(port_power_on_o) |-> !attach_report_o) else $error("attach reported unpowered");
    wake_powered_a: assert property (
        wake_event_o |-> $past(port_power_on_o) || $past(port_power_on_o, 2))
        else $error("wake while unpowered");
endmodule : usb_port_sc_checker

bind usb_port_status_control_upper usb_port_sc_checker chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_enabled_i(port_enabled_i),
    .connect_present_i(connect_present_i), .port_power_on_o(port_power_on_o),
    .companion_owns_o(companion_owns_o), .port_test_select_o(port_test_select_o),
    .test_drive_j_o(test_drive_j_o), .test_drive_k_o(test_drive_k_o),
    .test_se0_nak_o(test_se0_nak_o), .test_packet_o(test_packet_o),
    .test_force_enable_o(test_force_enable_o), .attach_report_o(attach_report_o),
    .wake_event_o(wake_event_o));

/* File: tb/usb_port_status_control_upper_tb_top.sv */
// self-checking bench for the port status and control upper fields
`timescale 1ns/1ps
module usb_port_status_control_upper_tb_top;
    import port_sc_pkg::*;
    localparam logic [7:0] SCR = PORT1_SC_OFS, CFR = CFG_FLAG_OFS, CAPR = PORT_CAP_OFS;
    logic        ref_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, port_test_select_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, dp_i, dm_i, overcurrent_i, port_enabled_i, connect_present_i;
    logic        port_power_on_o, companion_owns_o, test_drive_j_o, test_drive_k_o;
    logic        test_se0_nak_o, test_packet_o, test_force_enable_o, attach_report_o;
    logic        wake_event_o;
    int          mismatches = 0, comparisons = 0, wakes = 0;
    wire [4:0]   modes = {test_drive_j_o, test_drive_k_o, test_se0_nak_o, test_packet_o,
                          test_force_enable_o};

    usb_port_status_control_upper dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dp_i(dp_i), .dm_i(dm_i),
        .overcurrent_i(overcurrent_i), .port_enabled_i(port_enabled_i),
        .connect_present_i(connect_present_i), .port_power_on_o(port_power_on_o),
        .companion_owns_o(companion_owns_o), .port_test_select_o(port_test_select_o),
        .test_drive_j_o(test_drive_j_o), .test_drive_k_o(test_drive_k_o),
        .test_se0_nak_o(test_se0_nak_o), .test_packet_o(test_packet_o),
        .test_force_enable_o(test_force_enable_o), .attach_report_o(attach_report_o),
        .wake_event_o(wake_event_o));
    usb_device_model dev (
        .ref_clk_i(ref_clk_i), .dp_o(dp_i), .dm_o(dm_i), .connect_o(connect_present_i),
        .enabled_o(port_enabled_i), .overcurrent_o(overcurrent_i));

    // 10 mhz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // count wake pulses
    always @(posedge ref_clk_i)
        if (wake_event_o === 1'b1) wakes++;

    // one classic wishbone cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // only the watchdog ends a wait that never sees ack
        do begin
            @(posedge ref_clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic peek(input logic [7:0] adr, input string name, input logic [31:0] exp);
        bus(1'b0, adr, 4'hF, 32'h0000_0000);
        check(name, rd, exp);
    endtask : peek

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // watchdog well beyond the fewer than two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        mismatches++;
        $display("ERROR watchdog expected finished seen timeout");
        close_out();
    end

    // main sequence
    initial begin
        rst_n_i  = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        peek(SCR, "sc_reset", 32'h0000_2000);
        peek(CAPR, "cap_reset", 32'h0000_0001);
        peek(CFR, "cfg_reset", 32'h0000_0000);
        peek(8'h70, "unmapped", 32'h0000_0000);
        bus(1'b1, SCR, 4'hF, 32'hFFFF_FFFF);
        peek(SCR, "all_ones", 32'h0070_3000);
        // every test code, then a reserved one, then normal operation
        for (int k = 1; k <= 6; k++) begin
            bus(1'b1, SCR, 4'h6, 32'h0070_1000 | (32'(k) << 16));
            @(negedge ref_clk_i);
            check("test_sel", port_test_select_o, (k < 6) ? k : 5);
            check("test_mode", modes, 5'h10 >> (((k < 6) ? k : 5) - 1));
        end
        bus(1'b1, SCR, 4'h6, 32'h0070_1000);
        @(negedge ref_clk_i);
        check("test_off", {port_test_select_o, modes}, 9'h000);
        // ownership against the configure flag
        bus(1'b1, CFR, 4'h1, 32'h0000_0001);
        peek(SCR, "owner_cleared", 32'h0070_1000);
        bus(1'b1, SCR, 4'h2, 32'h0000_3000);
        check("owner_set", companion_owns_o, 1);
        bus(1'b1, CFR, 4'h1, 32'h0000_0000);
        bus(1'b1, SCR, 4'h2, 32'h0000_1000);
        peek(SCR, "owner_forced", 32'h0070_3000);
        bus(1'b1, CFR, 4'h1, 32'h0000_0001);
        peek(SCR, "owner_rise", 32'h0070_1000);
        // low-speed attach shows k, software hands the port over
        dev.attach(1'b1);
        repeat (6) @(posedge ref_clk_i);
        peek(SCR, "ls_attach", 32'h0070_1401);
        if (rd[11:10] == 2'b01) bus(1'b1, SCR, 4'h2, 32'h0000_3000);
        check("handoff", companion_owns_o, 1);
        dev.set_enabled(1'b1);
        repeat (2) @(posedge ref_clk_i);
        peek(SCR, "enabled", 32'h0070_3005);
        dev.set_enabled(1'b0);
        dev.detach();
        repeat (6) @(posedge ref_clk_i);
        peek(SCR, "detach", 32'h0070_3000);
        check("wakes_link", wakes, 2);
        // overcurrent drops power and wakes
        dev.set_oc(1'b1);
        repeat (6) @(posedge ref_clk_i);
        check("oc_power", port_power_on_o, 0);
        check("oc_wake", wakes, 3);
        peek(SCR, "unpowered", 32'h0000_2000);
        dev.set_oc(1'b0);
        // unpowered attach is neither reported nor woken on
        dev.attach(1'b0);
        repeat (6) @(posedge ref_clk_i);
        check("no_report", attach_report_o, 0);
        peek(SCR, "dark_attach", 32'h0000_2000);
        bus(1'b1, SCR, 4'h2, 32'h0000_3000);
        repeat (6) @(posedge ref_clk_i);
        check("report", attach_report_o, 1);
        peek(SCR, "fs_attach", 32'h0070_3801);
        check("no_dark_wake", wakes, 3);
        // switch off, then without switches the port is hard-wired on
        bus(1'b1, SCR, 4'h2, 32'h0000_2000);
        @(negedge ref_clk_i);
        check("switch_off", port_power_on_o, 0);
        bus(1'b1, CAPR, 4'h1, 32'h0000_0000);
        bus(1'b1, SCR, 4'h2, 32'h0000_2000);
        @(negedge ref_clk_i);
        check("hard_on", port_power_on_o, 1);
        peek(CAPR, "cap_off", 32'h0000_0000);
        close_out();
    end
endmodule : usb_port_status_control_upper_tb_top
